// [sim/froe_core_tb.sv]
// Testbench for the executor with a register file model.
// Drives words at the falling edge and checks settled outputs.
`timescale 1ns/100ps
module froe_core_tb;
   reg clock = 0, rst = 1, instr_valid = 0;
   reg [13:0] instr = 14'h0000;
   reg [7:0] page = 8'h08;
   wire [7:0] rdata, wdata, wreg;
   wire [6:0] addr;
   wire we, zf, sq;
   wire [14:0] pc;
   integer fails = 0, samples_checked = 0;
   froe_core i_froe_core (.clock(clock), .rst(rst), .ce(1'b1), .instr_valid(instr_valid),
      .instr(instr), .file_rdata(rdata), .page_latch_reg(page), .file_addr(addr),
      .file_wdata(wdata), .file_we(we), .pc(pc), .wreg(wreg), .zero_flag(zf), .squash(sq));
   froe_rf i_froe_rf (.clock(clock), .file_addr(addr), .file_wdata(wdata), .file_we(we),
      .file_rdata(rdata));
   initial forever #12.5 clock = ~clock;
   task op(input [13:0] w);
      @(negedge clock) instr = w;
      instr_valid = 1'b1;
      @(negedge clock) instr_valid = 1'b0;
   endtask
   task chk(input [15:0] g, input [15:0] e);
      samples_checked = samples_checked + 1;
      if (g !== e) begin
         fails = fails + 1;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task conclude;
      $display("Checks %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      i_froe_rf.mem[5] = 8'h01;
      i_froe_rf.mem[6] = 8'hff;
      i_froe_rf.mem[8] = 8'hff;
      repeat (3) @(posedge clock);
      @(negedge clock) rst = 1'b0;
      op(14'h0187);
      chk({zf, we, wdata}, 16'h0300);
      op(14'h0306);
      chk({zf, we, wreg}, 16'h00fe);
      op(14'h0100);
      chk({zf, wreg}, 16'h0100);
      op(14'h0386);
      chk({we, wdata}, 16'h01fe);
      op(14'h0b85);
      chk({sq, we, wdata}, 16'h0300);
      op(14'h3855);
      chk({sq, wreg}, 16'h0000);
      op(14'h0f08);
      chk({sq, zf, wreg}, 16'h0200);
      op(14'h3855);
      chk({sq, zf, wreg}, 16'h0000);
      op(14'h3855);
      chk({zf, wreg}, 16'h0055);
      op(14'h2805);
      chk({sq, pc}, 16'h8805);
      op(14'h3800);
      chk({sq, pc}, 16'h0806);
      conclude;
   end
endmodule

// [sim/froe_props.sv]
// Assertions on the executor ports.
// Bound to froe_core; sees its ports only.
`timescale 1ns/100ps
module froe_props #(parameter PCW = 15, parameter DW = 8) (
   input wire clock, // Clock
   input wire rst, // Reset
   input wire ce, // Enable
   input wire instr_valid, // Word valid
   input wire [13:0] instr, // Word
   input wire [DW-1:0] file_rdata, // Read data
   input wire [7:0] page_latch_reg, // Page latch
   input wire [DW-1:0] file_wdata, // Write data
   input wire file_we, // Write strobe
   input wire [PCW-1:0] pc, // Counter
   input wire [DW-1:0] wreg, // W
   input wire zero_flag, // Zero
   input wire squash // Discard
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   wire ex = ce & instr_valid & ~squash;
   AST_CLEAR_FILE_OP: assert property (ex && instr[13:7] == 7'h03 |=> file_we && !file_wdata && zero_flag)
      else $error("clear file");
   AST_DEC: assert property (ex && instr[13:8] == 6'h03 |=> file_we == $past(instr[7]) &&
      ($past(instr[7]) ? file_wdata : wreg) == $past(file_rdata) - 8'h01) else $error("dec");
   AST_CLEAR_WORKING_OP: assert property (ex && instr[13:7] == 7'h02 |=> !wreg && zero_flag)
      else $error("clear w");
   AST_DSZ: assert property (ex && instr[13:8] == 6'h0b |=>
      squash == ($past(file_rdata) == 8'h01) && $stable(zero_flag)) else $error("dsz");
   AST_ISZ: assert property (ex && instr[13:8] == 6'h0f |=>
      squash == ($past(file_rdata) == 8'hff) && $stable(zero_flag)) else $error("isz");
   AST_BR: assert property (ex && instr[13:11] == 3'h5 |=> squash &&
      pc == {$past(page_latch_reg[6:3]), $past(instr[10:0])}) else $error("branch");
   AST_OR: assert property (ex && instr[13:8] == 6'h38 |=> zero_flag == (wreg == 8'h00) &&
      wreg == ($past(wreg) | $past(instr[7:0]))) else $error("or");
   AST_SKIP: assert property (ce && instr_valid && squash |=> !file_we && !squash &&
      $stable(wreg) && $stable(zero_flag) && pc == $past(pc) + 1'b1) else $error("skip");
endmodule
bind froe_core froe_props #(.PCW(PCW), .DW(DW)) i_froe_props (.clock(clock), .rst(rst),
   .ce(ce), .instr_valid(instr_valid), .instr(instr), .file_rdata(file_rdata),
   .page_latch_reg(page_latch_reg), .file_wdata(file_wdata), .file_we(file_we), .pc(pc),
   .wreg(wreg), .zero_flag(zero_flag), .squash(squash));

// [sim/froe_rf.sv]
// Register file model facing the executor.
// Reads combinationally; writes at the clock edge while the strobe is high.
`timescale 1ns/100ps
module froe_rf (
   input wire clock, // Clock
   input wire [6:0] file_addr, // Address
   input wire [7:0] file_wdata, // Write data
   input wire file_we, // Write strobe
   output wire [7:0] file_rdata // Read data
);
   reg [7:0] mem [0:127];
   assign file_rdata = mem[file_addr];
   always @(posedge clock) begin
      if (file_we)
         mem[file_addr] <= file_wdata;
   end
endmodule

// [src/froe_alu.v]
// Eight-bit result unit for the executor: decrement, increment, OR, clear.
// Purely combinational; the caller registers the results.
`timescale 1ns/100ps
module froe_alu #(
   parameter W = 8
) (
   input wire [1:0] sel, // 0 dec, 1 inc, 2 or, 3 clear
   input wire [W-1:0] a, // Main operand
   input wire [W-1:0] b, // OR operand
   output reg [W-1:0] res, // Result
   output wire zero // Result equals zero
);
   always @* begin
      case (sel)
         2'h0: res = a - {{(W-1){1'b0}}, 1'b1};
         2'h1: res = a + {{(W-1){1'b0}}, 1'b1};
         2'h2: res = a | b;
         default: res = {W{1'b0}};
      endcase
   end

   assign zero = (res == {W{1'b0}});
endmodule

// [src/froe_core.v]
// Executor for clear, decrement, skip, branch and OR-literal instructions.
// Assumes the file register read data is valid combinationally for file_addr,
// and that the fetched word on instr is valid when instr_valid is high.
`timescale 1ns/100ps
`include "froe_regs.vh"

// Contract
// - clear_file_op zeroes register, sets zero flag
// - decrement_file_op result routed by destination bit
// - clear_working_op zeroes working register, sets zero
// - decrement_skip_zero_op skips next on zero result
// - increment_skip_zero_op skips next on zero result
// - Branch literal loads program counter bits 10:0
// - Page latch bits 6:3 give counter bits 14:11
// - Branch takes two cycles, second discarded
// - or_literal_op ORs literal into working, updates zero
module froe_core #(
   parameter PCW = 15,
   parameter DW = 8
) (
   input wire clock, // 40 MHz instruction clock
   input wire rst, // Synchronous reset, active high
   input wire ce, // Clock enable, freezes all state when low
   input wire instr_valid, // Fetched word on instr is valid
   input wire [`FROE_IW-1:0] instr, // Fetched instruction word
   input wire [DW-1:0] file_rdata, // Read data of addressed register
   input wire [7:0] page_latch_reg, // Page latch register value
   output wire [6:0] file_addr, // Register file address
   output reg [DW-1:0] file_wdata, // Register file write data
   output reg file_we, // Register file write strobe, one cycle
   output reg [PCW-1:0] pc, // Program counter
   output reg [DW-1:0] wreg, // Working register
   output reg zero_flag, // Zero status flag
   output reg squash // Current fetch is discarded
);
   wire is_clear_file_op;
   wire is_clear_working_op;
   wire is_decrement_file_op;
   wire is_decrement_skip_zero_op;
   wire is_increment_skip_zero_op;
   wire is_branch;
   wire is_orlit;
   wire dest_file;
   wire exec;
   reg [1:0] alu_sel;
   reg [DW-1:0] alu_a;
   wire [DW-1:0] alu_res;
   wire alu_zero;

   assign is_clear_file_op = instr[13:7] == `FROE_OPC_CLEAR_FILE_OP;
   assign is_clear_working_op = instr[13:7] == `FROE_OPC_CLEAR_WORKING_OP;
   assign is_decrement_file_op = instr[13:8] == `FROE_OPC_DECREMENT_FILE_OP;
   assign is_decrement_skip_zero_op = instr[13:8] == `FROE_OPC_DECREMENT_SKIP_ZERO_OP;
   assign is_increment_skip_zero_op = instr[13:8] == `FROE_OPC_INCREMENT_SKIP_ZERO_OP;
   assign is_branch = instr[13:11] == `FROE_OPC_BRANCH;
   assign is_orlit = instr[13:8] == `FROE_OPC_ORLIT;
   assign dest_file = instr[`FROE_DEST_BIT];
   assign file_addr = instr[`FROE_FADDR_MSB:0];
   // A squashed fetch executes as a no-operation.
   assign exec = instr_valid & ~squash;

   always @* begin
      alu_sel = 2'h3;
      alu_a = file_rdata;
      if (is_decrement_file_op | is_decrement_skip_zero_op) begin
         alu_sel = 2'h0;
      end else if (is_increment_skip_zero_op) begin
         alu_sel = 2'h1;
      end else if (is_orlit) begin
         alu_sel = 2'h2;
         alu_a = wreg;
      end
   end

   froe_alu #(
      .W(DW)
   ) u_alu (
      .sel(alu_sel),
      .a(alu_a),
      .b(instr[`FROE_LIT_MSB:0]),
      .res(alu_res),
      .zero(alu_zero)
   );

   always @(posedge clock) begin
      if (rst) begin
         pc <= `FROE_PC_RST;
         wreg <= `FROE_W_RST;
         zero_flag <= 1'b0;
         squash <= 1'b0;
         file_we <= 1'b0;
         file_wdata <= {DW{1'b0}};
      end else if (ce) begin
         file_we <= 1'b0;
         if (instr_valid) begin
            squash <= 1'b0;
            pc <= pc + {{(PCW-1){1'b0}}, 1'b1};
         end
         if (exec) begin
            if (is_clear_file_op) begin
               file_wdata <= {DW{1'b0}};
               file_we <= 1'b1;
               zero_flag <= 1'b1;
            end else if (is_clear_working_op) begin
               wreg <= {DW{1'b0}};
               zero_flag <= 1'b1;
            end else if (is_decrement_file_op | is_decrement_skip_zero_op | is_increment_skip_zero_op) begin
               if (dest_file) begin
                  file_wdata <= alu_res;
                  file_we <= 1'b1;
               end else begin
                  wreg <= alu_res;
               end
               if (is_decrement_file_op) begin
                  zero_flag <= alu_zero;
               end else begin
                  squash <= alu_zero;
               end
            end else if (is_branch) begin
               pc <= {page_latch_reg[`FROE_PAGE_MSB:`FROE_PAGE_LSB],
                      instr[`FROE_BR_MSB:0]};
               squash <= 1'b1;
            end else if (is_orlit) begin
               wreg <= alu_res;
               zero_flag <= alu_zero;
            end
         end
      end
   end
endmodule

// [src/froe_regs.vh]
// Constants for the file register operation executor.
// Included by the core design file; holds definitions only.
`ifndef FROE_REGS_VH
`define FROE_REGS_VH

// Instruction word fields (14-bit word).
`define FROE_IW 14
`define FROE_FADDR_MSB 6
`define FROE_DEST_BIT 7
`define FROE_LIT_MSB 7
`define FROE_BR_MSB 10

// Opcode patterns: upper bits compared against the word.
`define FROE_OPC_CLEAR_FILE_OP 7'h03
`define FROE_OPC_CLEAR_WORKING_OP 7'h02
`define FROE_OPC_DECREMENT_FILE_OP 6'h03
`define FROE_OPC_DECREMENT_SKIP_ZERO_OP 6'h0b
`define FROE_OPC_INCREMENT_SKIP_ZERO_OP 6'h0f
`define FROE_OPC_BRANCH 3'h5
`define FROE_OPC_ORLIT 6'h38

// Page latch field feeding the upper program counter bits.
`define FROE_PAGE_LSB 3
`define FROE_PAGE_MSB 6

// Reset values.
`define FROE_PC_RST 15'h0000
`define FROE_W_RST 8'h00

`endif
